// ### verilog/led_strap_pkg.sv
// constants for the port indicator selector and boot width strap block
// assumes a word-wide ahb-lite slave window of three registers
package led_strap_pkg;

  // register byte offsets
  localparam logic [31:0] wan_misc_ctrl_offset    = 32'h0000_0000;
  localparam logic [31:0] switch_ctrl0_offset     = 32'h0000_0004;
  localparam logic [31:0] indicator_status_offset = 32'h0000_0008;

  // select field positions and width
  localparam int sel_width       = 3;
  localparam int wan_ind0_sel_lsb = 0;
  localparam int wan_ind1_sel_lsb = 4;
  localparam int lan_ind0_sel_lsb = 25;
  localparam int lan_ind1_sel_lsb = 22;

  // status register field positions
  localparam int stat_width_lsb    = 0;
  localparam int stat_reserved_bit = 2;
  localparam int stat_captured_bit = 3;
  localparam int stat_wan_lsb      = 4;
  localparam int stat_lan0_lsb     = 6;
  localparam int stat_lan1_lsb     = 10;
  localparam int stat_lan_slots    = 4;

  // indicator source codes
  typedef enum logic [2:0] {
    src_speed         = 3'h0,
    src_link          = 3'h1,
    src_duplex        = 3'h2,
    src_collision     = 3'h3,
    src_activity      = 3'h4,
    src_fdx_collision = 3'h5,
    src_link_activity = 3'h6,
    src_none          = 3'h7
  } led_source_type;

  // select values after reset
  localparam logic [2:0] wan_ind0_sel_reset = 3'h6;
  localparam logic [2:0] wan_ind1_sel_reset = 3'h0;
  localparam logic [2:0] lan_ind0_sel_reset = 3'h6;
  localparam logic [2:0] lan_ind1_sel_reset = 3'h0;

  // boot bank width codes
  typedef enum logic [1:0] {
    width_reserved = 2'h0,
    width_byte     = 2'h1,
    width_half     = 2'h2,
    width_word     = 2'h3
  } boot_width_type;
  localparam logic [1:0] boot_width_reset = 2'h0;

  // strap capture sequence
  typedef enum logic [2:0] {
    strap_wait    = 3'b001,
    strap_capture = 3'b010,
    strap_run     = 3'b100
  } strap_state_type;

  // least reset hold expected of the reset source, in hclk cycles
  localparam int reset_hold_cycles = 256;

  // ahb-lite encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic       hresp_okay    = 1'b0;

endpackage

// ### verilog/indicator_source_mux.sv
// one indicator: picks a status source by a 3-bit select code
// assumes status inputs are levels on the hclk domain
`timescale 1ns/1ps
module indicator_source_mux (
  // source selection
  input  wire logic [2:0] sel,
  // port status
  input  wire logic       speed,
  input  wire logic       link,
  input  wire logic       duplex,
  input  wire logic       collision,
  input  wire logic       activity,
  // result, high means lit
  output      logic       lit
);

  // combined sources
  wire fdx_collision = collision & duplex;
  // dark while traffic flows, so activity shows as flicker
  wire link_activity = link & ~activity;

  // code to source map, unknown code keeps the indicator dark
  always_comb begin
    case (sel)
      led_strap_pkg::src_speed:         lit = speed;
      led_strap_pkg::src_link:          lit = link;
      led_strap_pkg::src_duplex:        lit = duplex;
      led_strap_pkg::src_collision:     lit = collision;
      led_strap_pkg::src_activity:      lit = activity;
      led_strap_pkg::src_fdx_collision: lit = fdx_collision;
      led_strap_pkg::src_link_activity: lit = link_activity;
      default:                          lit = 1'b0;
    endcase
  end

endmodule

// ### verilog/led_strap_ctrl.sv
// port indicator selector with boot bank width strap capture
// assumes status inputs on hclk, strap pins asynchronous, one ahb master
`timescale 1ns/1ps
module led_strap_ctrl #(
  parameter int lan_ports = 4
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [31:0]          hwdata,
  output      logic [31:0]          hrdata,
  output      logic                 hreadyout,
  output      logic                 hresp,
  // wan port status
  input  wire logic                 wan_speed,
  input  wire logic                 wan_link,
  input  wire logic                 wan_duplex,
  input  wire logic                 wan_collision,
  input  wire logic                 wan_activity,
  // lan port status, bit 0 is port 1
  input  wire logic [lan_ports-1:0] lan_speed,
  input  wire logic [lan_ports-1:0] lan_link,
  input  wire logic [lan_ports-1:0] lan_duplex,
  input  wire logic [lan_ports-1:0] lan_collision,
  input  wire logic [lan_ports-1:0] lan_activity,
  // wan indicator zero pin, doubles as width strap bit 0
  input  wire logic                 wan_indicator_zero_in,
  output      logic                 wan_indicator_zero_out,
  output      logic                 wan_indicator_zero_oe_n,
  // wan indicator one pin, doubles as width strap bit 1
  input  wire logic                 wan_indicator_one_in,
  output      logic                 wan_indicator_one_out,
  output      logic                 wan_indicator_one_oe_n,
  // lan indicators, bit 0 is port 1
  output      logic [lan_ports-1:0] lan_port_indicator_zero,
  output      logic [lan_ports-1:0] lan_port_indicator_one,
  // captured boot bank width
  output      logic [1:0]           boot_bank_width_strap,
  output      logic                 boot_width_valid,
  output      logic                 boot_width_reserved
);

  // refuse port counts the status layout cannot hold
  if (lan_ports < 1 || lan_ports > led_strap_pkg::stat_lan_slots) begin : g_chk
    $error("lan_ports must be 1 to 4");
  end

  // word address compare, low two bits ignored
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [31:0] offset);
    reg_hit = (addr[31:2] == offset[31:2]);
  endfunction

  // ahb address phase decode
  wire addr_valid = hsel & hready & htrans[1];
  wire wr_req     = addr_valid & hwrite;
  wire rd_req     = addr_valid & ~hwrite;

  // pending write captured from the address phase
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend_ff <= wr_req;
      wr_addr_ff <= haddr;
    end
  end

  // data phase write strobes
  wire wr_wan_misc = wr_pend_ff &
                     reg_hit(wr_addr_ff, led_strap_pkg::wan_misc_ctrl_offset);
  wire wr_switch0  = wr_pend_ff &
                     reg_hit(wr_addr_ff, led_strap_pkg::switch_ctrl0_offset);

  // select registers
  logic [2:0] wan0_sel_ff;
  logic [2:0] wan1_sel_ff;
  logic [2:0] lan0_sel_ff;
  logic [2:0] lan1_sel_ff;

  // next select values, only the select fields are stored
  wire [2:0] nxt_wan0_sel = wr_wan_misc ?
    hwdata[led_strap_pkg::wan_ind0_sel_lsb +: led_strap_pkg::sel_width] :
    wan0_sel_ff;
  wire [2:0] nxt_wan1_sel = wr_wan_misc ?
    hwdata[led_strap_pkg::wan_ind1_sel_lsb +: led_strap_pkg::sel_width] :
    wan1_sel_ff;
  wire [2:0] nxt_lan0_sel = wr_switch0 ?
    hwdata[led_strap_pkg::lan_ind0_sel_lsb +: led_strap_pkg::sel_width] :
    lan0_sel_ff;
  wire [2:0] nxt_lan1_sel = wr_switch0 ?
    hwdata[led_strap_pkg::lan_ind1_sel_lsb +: led_strap_pkg::sel_width] :
    lan1_sel_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wan0_sel_ff <= led_strap_pkg::wan_ind0_sel_reset;
      wan1_sel_ff <= led_strap_pkg::wan_ind1_sel_reset;
      lan0_sel_ff <= led_strap_pkg::lan_ind0_sel_reset;
      lan1_sel_ff <= led_strap_pkg::lan_ind1_sel_reset;
    end else begin
      wan0_sel_ff <= nxt_wan0_sel;
      wan1_sel_ff <= nxt_wan1_sel;
      lan0_sel_ff <= nxt_lan0_sel;
      lan1_sel_ff <= nxt_lan1_sel;
    end
  end

  // strap pin synchronisers, free running so they fill during reset
  logic [1:0] strap_meta_ff;
  logic [1:0] strap_sync_ff;

  always_ff @(posedge hclk) begin
    strap_meta_ff <= {wan_indicator_one_in, wan_indicator_zero_in};
    strap_sync_ff <= strap_meta_ff;
  end

  // strap capture sequence after reset release
  led_strap_pkg::strap_state_type strap_state_ff;
  led_strap_pkg::strap_state_type nxt_strap_state;

  always_comb begin
    case (strap_state_ff)
      led_strap_pkg::strap_wait:    nxt_strap_state =
                                      led_strap_pkg::strap_capture;
      led_strap_pkg::strap_capture: nxt_strap_state =
                                      led_strap_pkg::strap_run;
      led_strap_pkg::strap_run:     nxt_strap_state =
                                      led_strap_pkg::strap_run;
      default:                      nxt_strap_state =
                                      led_strap_pkg::strap_wait;
    endcase
  end

  wire capture_now = (strap_state_ff == led_strap_pkg::strap_capture);
  wire entering_run = (nxt_strap_state == led_strap_pkg::strap_run);

  // captured width, reserved flag and pin direction
  logic [1:0] width_ff;
  logic       width_valid_ff;
  logic       width_reserved_ff;
  logic       pins_oe_n_ff;

  // width is taken from pins still released, so no self readback
  wire width_is_reserved =
    (strap_sync_ff == led_strap_pkg::width_reserved);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_state_ff    <= led_strap_pkg::strap_wait;
      width_ff          <= led_strap_pkg::boot_width_reset;
      width_valid_ff    <= 1'b0;
      width_reserved_ff <= 1'b0;
      pins_oe_n_ff      <= 1'b1;
    end else begin
      strap_state_ff <= nxt_strap_state;
      if (capture_now) begin
        width_ff          <= strap_sync_ff;
        width_valid_ff    <= 1'b1;
        width_reserved_ff <= width_is_reserved;
      end
      pins_oe_n_ff <= ~entering_run;
    end
  end

  // indicator source selection, wan first then each lan port
  logic                 wan0_lit;
  logic                 wan1_lit;
  logic [lan_ports-1:0] lan0_lit;
  logic [lan_ports-1:0] lan1_lit;

  indicator_source_mux u_wan0 (
    .sel       (wan0_sel_ff),
    .speed     (wan_speed),
    .link      (wan_link),
    .duplex    (wan_duplex),
    .collision (wan_collision),
    .activity  (wan_activity),
    .lit       (wan0_lit)
  );

  indicator_source_mux u_wan1 (
    .sel       (wan1_sel_ff),
    .speed     (wan_speed),
    .link      (wan_link),
    .duplex    (wan_duplex),
    .collision (wan_collision),
    .activity  (wan_activity),
    .lit       (wan1_lit)
  );

  // every port sees the shared select but only its own status
  for (genvar p = 0; p < lan_ports; p++) begin : g_lan
    indicator_source_mux u_ind0 (
      .sel       (lan0_sel_ff),
      .speed     (lan_speed[p]),
      .link      (lan_link[p]),
      .duplex    (lan_duplex[p]),
      .collision (lan_collision[p]),
      .activity  (lan_activity[p]),
      .lit       (lan0_lit[p])
    );
    indicator_source_mux u_ind1 (
      .sel       (lan1_sel_ff),
      .speed     (lan_speed[p]),
      .link      (lan_link[p]),
      .duplex    (lan_duplex[p]),
      .collision (lan_collision[p]),
      .activity  (lan_activity[p]),
      .lit       (lan1_lit[p])
    );
  end

  // registered indicator levels, dark through reset
  logic                 wan0_out_ff;
  logic                 wan1_out_ff;
  logic [lan_ports-1:0] lan0_out_ff;
  logic [lan_ports-1:0] lan1_out_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wan0_out_ff <= 1'b0;
      wan1_out_ff <= 1'b0;
      lan0_out_ff <= '0;
      lan1_out_ff <= '0;
    end else begin
      wan0_out_ff <= wan0_lit;
      wan1_out_ff <= wan1_lit;
      lan0_out_ff <= lan0_lit;
      lan1_out_ff <= lan1_lit;
    end
  end

  // lan levels padded to the fixed status slots
  logic [3:0] lan0_slot;
  logic [3:0] lan1_slot;

  for (genvar s = 0; s < led_strap_pkg::stat_lan_slots; s++) begin : g_slot
    if (s < lan_ports) begin : g_used
      assign lan0_slot[s] = lan0_out_ff[s];
      assign lan1_slot[s] = lan1_out_ff[s];
    end else begin : g_empty
      assign lan0_slot[s] = 1'b0;
      assign lan1_slot[s] = 1'b0;
    end
  end

  // status word: width, flags and current indicator levels
  wire [31:0] status_word = {
    18'h0_0000,
    lan1_slot,
    lan0_slot,
    wan1_out_ff,
    wan0_out_ff,
    width_valid_ff,
    width_reserved_ff,
    width_ff
  };

  // read mux uses next select values so a read right after a write
  // sees the new value
  wire [31:0] wan_misc_word = {25'h000_0000, nxt_wan1_sel, 1'b0,
                               nxt_wan0_sel};
  wire [31:0] switch0_word  = {4'h0, nxt_lan0_sel, nxt_lan1_sel,
                               22'h00_0000};
  wire hit_wan_misc = reg_hit(haddr, led_strap_pkg::wan_misc_ctrl_offset);
  wire hit_switch0  = reg_hit(haddr, led_strap_pkg::switch_ctrl0_offset);
  wire hit_status   = reg_hit(haddr, led_strap_pkg::indicator_status_offset);
  wire [31:0] nxt_rdata = hit_wan_misc ? wan_misc_word :
                          hit_switch0  ? switch0_word  :
                          hit_status   ? status_word   : 32'h0000_0000;

  // bus answer: zero wait, always okay, unmapped reads zero
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= led_strap_pkg::hresp_okay;
    end else begin
      if (rd_req) begin
        hrdata_ff <= nxt_rdata;
      end
      hreadyout_ff <= 1'b1;
      hresp_ff     <= led_strap_pkg::hresp_okay;
    end
  end

  // output drive, pins released until the strap has been taken
  assign hrdata                  = hrdata_ff;
  assign hreadyout               = hreadyout_ff;
  assign hresp                   = hresp_ff;
  assign wan_indicator_zero_out  = wan0_out_ff;
  assign wan_indicator_one_out   = wan1_out_ff;
  assign wan_indicator_zero_oe_n = pins_oe_n_ff;
  assign wan_indicator_one_oe_n  = pins_oe_n_ff;
  assign lan_port_indicator_zero = lan0_out_ff;
  assign lan_port_indicator_one  = lan1_out_ff;
  assign boot_bank_width_strap   = width_ff;
  assign boot_width_valid        = width_valid_ff;
  assign boot_width_reserved     = width_reserved_ff;

endmodule

// ### tb/led_strap_checker.sv
// checker for the indicator selector and width strap ports
// assumes hready is the slave's own hreadyout
`timescale 1ns/1ps
module led_strap_checker #(
  parameter int lan_ports = 4
) (
  // clock and reset
  input wire logic                 hclk,
  input wire logic                 hresetn,
  // bus
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic [31:0]          hwdata,
  // port status
  input wire logic                 wan_speed,
  input wire logic                 wan_link,
  input wire logic                 wan_duplex,
  input wire logic                 wan_collision,
  input wire logic                 wan_activity,
  input wire logic [lan_ports-1:0] lan_speed,
  input wire logic [lan_ports-1:0] lan_link,
  input wire logic [lan_ports-1:0] lan_duplex,
  input wire logic [lan_ports-1:0] lan_collision,
  input wire logic [lan_ports-1:0] lan_activity,
  // pins and strap
  input wire logic                 wan_indicator_zero_in,
  input wire logic                 wan_indicator_zero_out,
  input wire logic                 wan_indicator_zero_oe_n,
  input wire logic                 wan_indicator_one_in,
  input wire logic                 wan_indicator_one_out,
  input wire logic                 wan_indicator_one_oe_n,
  input wire logic [lan_ports-1:0] lan_port_indicator_zero,
  input wire logic [lan_ports-1:0] lan_port_indicator_one,
  input wire logic [1:0]           boot_bank_width_strap,
  input wire logic                 boot_width_valid,
  input wire logic                 boot_width_reserved
);
  logic [2:0]             w0_ff, w1_ff, l0_ff, l1_ff;
  logic                   wp_ff, lp_ff;
  wire logic              take = hsel & hready & htrans[1] & hwrite;
  wire logic [4:0]        wst = {wan_activity, wan_collision, wan_duplex,
                                 wan_link, wan_speed};
  wire logic [5*lan_ports-1:0] lst = {lan_activity, lan_collision,
                                      lan_duplex, lan_link, lan_speed};
  // select shadow, loaded in the write data phase like the real one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_ff <= 1'b0;
      lp_ff <= 1'b0;
      w0_ff <= led_strap_pkg::wan_ind0_sel_reset;
      w1_ff <= led_strap_pkg::wan_ind1_sel_reset;
      l0_ff <= led_strap_pkg::lan_ind0_sel_reset;
      l1_ff <= led_strap_pkg::lan_ind1_sel_reset;
    end else if (hready) begin
      wp_ff <= take && haddr[31:2] == 30'h0;
      lp_ff <= take && haddr[31:2] == 30'h1;
      if (wp_ff) begin
        w0_ff <= hwdata[2:0];
        w1_ff <= hwdata[6:4];
      end
      if (lp_ff) begin
        l0_ff <= hwdata[27:25];
        l1_ff <= hwdata[24:22];
      end
    end
  end
  // source of one indicator; code 111 stays dark
  function automatic logic pick(logic [2:0] s, logic [4:0] st);
    return s < 3'h5 ? st[s] : s == 3'h5 ? st[3] & st[2] :
           s == 3'h6 ? st[1] & ~st[4] : 1'b0;
  endfunction
  function automatic logic [lan_ports-1:0] lpick(logic [2:0] s,
                                                 logic [5*lan_ports-1:0] v);
    logic [lan_ports-1:0] r;
    for (int p = 0; p < lan_ports; p++) begin
      r[p] = pick(s, {v[4*lan_ports+p], v[3*lan_ports+p],
                      v[2*lan_ports+p], v[lan_ports+p], v[p]});
    end
    return r;
  endfunction
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rel;
    $rose(hresetn);
  endsequence
  sequence s_off;
    wan_indicator_zero_oe_n && wan_indicator_one_oe_n;
  endsequence
  AST_WAN0: assert property ($past(hresetn) |->
    wan_indicator_zero_out == pick($past(w0_ff), $past(wst)))
    else $error("wan indicator zero shows wrong source");
  AST_WAN1: assert property ($past(hresetn) |->
    wan_indicator_one_out == pick($past(w1_ff), $past(wst)))
    else $error("wan indicator one shows wrong source");
  AST_LAN0: assert property ($past(hresetn) |->
    lan_port_indicator_zero == lpick($past(l0_ff), $past(lst)))
    else $error("lan indicator zero shows wrong source");
  AST_LAN1: assert property ($past(hresetn) |->
    lan_port_indicator_one == lpick($past(l1_ff), $past(lst)))
    else $error("lan indicator one shows wrong source");
  AST_PINS_RELEASED: assert property (s_rel |-> s_off ##1 s_off
    ##1 !wan_indicator_zero_oe_n && !wan_indicator_one_oe_n)
    else $error("wan pins driven too early or not at all");
  AST_PINS_DRIVEN: assert property (boot_width_valid |->
    !wan_indicator_zero_oe_n && !wan_indicator_one_oe_n)
    else $error("wan pins undriven after capture");
  AST_CAPTURE: assert property (s_rel |-> ##2 boot_width_valid &&
    boot_bank_width_strap == {$past(wan_indicator_one_in, 2),
                              $past(wan_indicator_zero_in, 2)})
    else $error("boot width not captured from pins");
  AST_HELD: assert property (boot_width_valid |=>
    boot_width_valid && $stable(boot_bank_width_strap))
    else $error("boot width changed after capture");
  AST_RESERVED: assert property (boot_width_valid |->
    boot_width_reserved == (boot_bank_width_strap == 2'h0))
    else $error("reserved width flag wrong");
endmodule
bind led_strap_ctrl led_strap_checker #(.lan_ports(lan_ports)) i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .wan_speed, .wan_link, .wan_duplex, .wan_collision, .wan_activity,
  .lan_speed, .lan_link, .lan_duplex, .lan_collision, .lan_activity,
  .wan_indicator_zero_in, .wan_indicator_zero_out, .wan_indicator_zero_oe_n,
  .wan_indicator_one_in, .wan_indicator_one_out, .wan_indicator_one_oe_n,
  .lan_port_indicator_zero, .lan_port_indicator_one,
  .boot_bank_width_strap, .boot_width_valid, .boot_width_reserved);

// ### tb/led_board_model.sv
// board model: the two shared wan pins with their strap resistors
// assumes a pin is driven only while its enable is low
`timescale 1ns/1ps
module led_board_model (
  // strap fitted on the board
  input  wire logic [1:0] strap_code,
  // device side of the pins
  input  wire logic       pin_zero_out,
  input  wire logic       pin_zero_oe_n,
  input  wire logic       pin_one_out,
  input  wire logic       pin_one_oe_n,
  // resolved pin levels
  output      logic       pin_zero_level,
  output      logic       pin_one_level
);
  // the resistor only wins while the device lets go of the pin
  assign pin_zero_level = pin_zero_oe_n ? strap_code[0]
                                        : pin_zero_out;
  assign pin_one_level  = pin_one_oe_n ? strap_code[1]
                                       : pin_one_out;
endmodule

// ### tb/test_phy_led_select_and_boot_strap.sv
// testbench: strap capture, register map and indicator source selection
// assumes the board model resolves the two shared wan pins
`timescale 1ns/1ps
module test_phy_led_select_and_boot_strap;
  // bus and reset
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0, strap = 2'h3;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  // port status
  logic [4:0]  wst = 5'h0;
  logic [3:0]  lsp = 4'h0, llk = 4'h0, ldx = 4'h0, lco = 4'h0, lac = 4'h0;
  // design outputs
  wire logic [31:0] hrdata;
  wire logic        rdy, hresp, pin0, pin1, wo0, wo1, woe0, woe1, bv, br;
  wire logic [3:0]  li0, li1;
  wire logic [1:0]  bw;
  int               fail_count = 0, n_compared = 0;
  always #2 hclk = ~hclk;
  led_strap_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(rdy), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy),
    .hresp(hresp), .wan_speed(wst[0]), .wan_link(wst[1]),
    .wan_duplex(wst[2]), .wan_collision(wst[3]), .wan_activity(wst[4]),
    .lan_speed(lsp), .lan_link(llk), .lan_duplex(ldx), .lan_collision(lco),
    .lan_activity(lac), .wan_indicator_zero_in(pin0),
    .wan_indicator_zero_out(wo0), .wan_indicator_zero_oe_n(woe0),
    .wan_indicator_one_in(pin1), .wan_indicator_one_out(wo1),
    .wan_indicator_one_oe_n(woe1), .lan_port_indicator_zero(li0),
    .lan_port_indicator_one(li1), .boot_bank_width_strap(bw),
    .boot_width_valid(bv), .boot_width_reserved(br));
  led_board_model i_board (.strap_code(strap), .pin_zero_out(wo0),
    .pin_zero_oe_n(woe0), .pin_one_out(wo1), .pin_one_oe_n(woe1),
    .pin_zero_level(pin0), .pin_one_level(pin1));
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for hready, up to 20 cycles, though the slave answers every phase with zero wait
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      chk("hreadyout", 32'h1, 32'(rdy));
      test_done();
    end
  endtask
  task automatic ahb(logic w, logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= led_strap_pkg::htrans_nonseq;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'(led_strap_pkg::hresp_okay), 32'(hresp));
  endtask
  // one reset with a given strap, held the full documented time
  task automatic t_strap(logic [1:0] code);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap <= code; // 00 is fitted on purpose once
    repeat (led_strap_pkg::reset_hold_cycles) @(posedge hclk);
    @(negedge hclk);
    chk("oe_n in reset", 32'h3, {woe1, woe0});
    chk("valid in reset", 32'h0, 32'(bv));
    // release on a rising edge, like every other input
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("oe_n", 32'h0, {woe1, woe0});
    chk("valid", 32'h1, 32'(bv));
    chk("width", 32'(code), 32'(bw));
    chk("reserved", 32'(code == 2'h0), 32'(br));
  endtask
  task automatic t_regs;
    logic [31:0] rd;
    ahb(0, led_strap_pkg::wan_misc_ctrl_offset, 0, rd);
    chk("wan ctrl reset", 32'h6, rd);
    ahb(0, led_strap_pkg::switch_ctrl0_offset, 0, rd);
    chk("switch ctrl reset", 32'h0c00_0000, rd);
    ahb(1, led_strap_pkg::wan_misc_ctrl_offset, 32'hffff_ffff, rd);
    ahb(0, led_strap_pkg::wan_misc_ctrl_offset, 0, rd);
    chk("wan ctrl fields", 32'h77, rd);
    ahb(1, led_strap_pkg::switch_ctrl0_offset, 32'hffff_ffff, rd);
    ahb(0, led_strap_pkg::switch_ctrl0_offset, 0, rd);
    chk("switch ctrl fields", 32'h0fc0_0000, rd);
    ahb(1, led_strap_pkg::indicator_status_offset, 32'h0, rd);
    ahb(0, led_strap_pkg::indicator_status_offset, 0, rd);
    chk("status width", 32'hb, 32'(rd[3:0]));
    ahb(1, 32'h10, 32'hffff_ffff, rd);
    ahb(0, 32'h10, 0, rd);
    chk("unmapped read", 32'h0, rd);
  endtask
  function automatic logic lit(logic [2:0] s, logic [4:0] st);
    return s < 3'h5 ? st[s] : s == 3'h5 ? st[3] & st[2] :
           s == 3'h6 ? st[1] & ~st[4] : 1'b0;
  endfunction
  // every code on both wan indicators against every status pattern
  task automatic t_wan;
    logic [31:0] rd;
    for (int c = 0; c < 8; c++) begin
      ahb(1, led_strap_pkg::wan_misc_ctrl_offset,
          {25'h0, ~3'(c), 1'b0, 3'(c)}, rd);
      for (int v = 0; v < 32; v++) begin
        @(posedge hclk);
        wst <= 5'(v);
        @(posedge hclk);
        @(negedge hclk);
        chk("wan zero", 32'(lit(3'(c), wst)), 32'(wo0));
        chk("wan one", 32'(lit(~3'(c), wst)), 32'(wo1));
      end
    end
  endtask
  // distinct status per lan port so a swapped port shows
  task automatic t_lan;
    logic [31:0] rd;
    logic [3:0]  e0, e1;
    for (int c = 0; c < 8; c++) begin
      ahb(1, led_strap_pkg::switch_ctrl0_offset,
          {4'h0, 3'(c), ~3'(c), 22'h0}, rd);
      for (int k = 0; k < 16; k++) begin
        @(posedge hclk);
        {lsp, llk, ldx} <= {4'(k), ~4'(k), 4'(k) ^ 4'h5};
        {lco, lac} <= {4'(k) + 4'h7, 4'(k) ^ 4'h3};
        @(posedge hclk);
        @(negedge hclk);
        for (int p = 0; p < 4; p++) begin
          e0[p] = lit(3'(c), {lac[p], lco[p], ldx[p], llk[p], lsp[p]});
          e1[p] = lit(~3'(c), {lac[p], lco[p], ldx[p], llk[p], lsp[p]});
        end
        chk("lan zero", 32'(e0), 32'(li0));
        chk("lan one", 32'(e1), 32'(li1));
      end
    end
    chk("width held", 32'h3, 32'(bw));
    // last settings: wan one and lan one show speed, the others dark
    ahb(0, led_strap_pkg::indicator_status_offset, 0, rd);
    chk("status levels", 32'h0000_3c2b, rd);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    for (int c = 0; c < 4; c++) t_strap(2'(c));
    t_regs();
    t_wan();
    t_lan();
    test_done();
  end
endmodule
